/* ramp_bound_recal_config_regs.sv */
`timescale 1ns/1ps
module ramp_bound_recal_config_regs (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic ramp_req_valid,
   input wire logic [32:0] ramp_req_code,
   input wire logic cal_done,
   input wire logic [2:0] osc_core_choice,
   input wire logic [8:0] osc_bias_initial,
   input wire logic [2:0] cur_core,
   input wire logic [7:0] osc_cap_code,
   input wire logic [8:0] cur_bias,
   output logic [32:0] ramp_offset,
   output logic [32:0] ramp_recal_threshold,
   output logic [32:0] upper_bound_code,
   output logic recal_needed,
   output logic fast_recal_select,
   output logic [7:0] osc_cap_start_code,
   output logic [2:0] start_core,
   output logic [7:0] start_cap,
   output logic [8:0] start_bias
);
   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   function automatic logic map_hit(input logic [11:0] a);
      logic [7:0] idx;
      idx = a[9:2];
      map_hit = (a[1:0] == 2'h0) && (a[11:10] == 2'h0) &&
                (((idx >= ramp_cfg_pkg::IDX_SPARE_WORD_A) &&
                  (idx <= ramp_cfg_pkg::IDX_BOUND_LOWER)) ||
                 (idx == ramp_cfg_pkg::IDX_RAMP_STATUS));
   endfunction

   function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] wd,
                                         input logic [3:0] be);
      merge = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
   endfunction

   // Unsigned gap between two codes; the ramp may run either way
   function automatic logic [32:0] code_gap(input logic [32:0] a, input logic [32:0] b);
      if (a >= b) begin
         code_gap = a - b;
      end else begin
         code_gap = b - a;
      end
   endfunction

   // ----------------------------------------------------------------
   // Register state
   // ----------------------------------------------------------------
   logic [15:0] spare_word_a_q;
   logic [15:0] spare_word_a_d;
   logic [15:0] calibration_start_and_threshold_top_q;
   logic [15:0] calibration_start_and_threshold_top_d;
   logic [15:0] recal_threshold_upper_half_q;
   logic [15:0] recal_threshold_upper_half_d;
   logic [15:0] recal_threshold_lower_half_q;
   logic [15:0] recal_threshold_lower_half_d;
   logic [15:0] upper_bound_top_bit_q;
   logic [15:0] upper_bound_top_bit_d;
   logic [15:0] upper_bound_upper_half_q;
   logic [15:0] upper_bound_upper_half_d;
   logic [15:0] upper_bound_lower_half_q;
   logic [15:0] upper_bound_lower_half_d;
   logic [31:0] prdata_q;
   logic [31:0] prdata_d;
   logic [7:0] idx;
   logic wr_en;
   logic rd_setup;
   logic clamped;
   logic [15:0] status_word;
   logic [15:0] rd_word;

   // ----------------------------------------------------------------
   // Bus handshake
   // ----------------------------------------------------------------
   assign idx = paddr[9:2];
   // Writes land only at the access edge; unmapped writes are dropped
   assign wr_en = psel && penable && pwrite && map_hit(paddr);
   assign rd_setup = psel && !penable && !pwrite;
   // Zero wait states: every word already sits in a flop or a wire
   assign pready = 1'b1;
   // Writes to the read-only status index are dropped without an error
   assign pslverr = psel && penable && !map_hit(paddr);
   assign prdata = prdata_q;

   // ----------------------------------------------------------------
   // Register writes
   // ----------------------------------------------------------------
   always_comb begin
      spare_word_a_d = spare_word_a_q;
      calibration_start_and_threshold_top_d = calibration_start_and_threshold_top_q;
      recal_threshold_upper_half_d = recal_threshold_upper_half_q;
      recal_threshold_lower_half_d = recal_threshold_lower_half_q;
      upper_bound_top_bit_d = upper_bound_top_bit_q;
      upper_bound_upper_half_d = upper_bound_upper_half_q;
      upper_bound_lower_half_d = upper_bound_lower_half_q;
      // Strobed bytes kept as written, reserved bits too
      if (wr_en) begin
         unique case (idx)
            ramp_cfg_pkg::IDX_SPARE_WORD_A: begin
               spare_word_a_d = merge(spare_word_a_q, pwdata, pstrb);
            end
            ramp_cfg_pkg::IDX_CAL_START: begin
               calibration_start_and_threshold_top_d =
                  merge(calibration_start_and_threshold_top_q, pwdata, pstrb);
            end
            ramp_cfg_pkg::IDX_THRESH_UPPER: begin
               recal_threshold_upper_half_d = merge(recal_threshold_upper_half_q, pwdata, pstrb);
            end
            ramp_cfg_pkg::IDX_THRESH_LOWER: begin
               recal_threshold_lower_half_d = merge(recal_threshold_lower_half_q, pwdata, pstrb);
            end
            ramp_cfg_pkg::IDX_BOUND_TOP: begin
               upper_bound_top_bit_d = merge(upper_bound_top_bit_q, pwdata, pstrb);
            end
            ramp_cfg_pkg::IDX_BOUND_UPPER: begin
               upper_bound_upper_half_d = merge(upper_bound_upper_half_q, pwdata, pstrb);
            end
            ramp_cfg_pkg::IDX_BOUND_LOWER: begin
               upper_bound_lower_half_d = merge(upper_bound_lower_half_q, pwdata, pstrb);
            end
            default: begin
               // Status word is read only
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         spare_word_a_q <= ramp_cfg_pkg::RST_SPARE_WORD_A;
         calibration_start_and_threshold_top_q <= ramp_cfg_pkg::RST_CAL_START;
         recal_threshold_upper_half_q <= ramp_cfg_pkg::RST_THRESH_UPPER;
         recal_threshold_lower_half_q <= ramp_cfg_pkg::RST_THRESH_LOWER;
         upper_bound_top_bit_q <= ramp_cfg_pkg::RST_BOUND_TOP;
         upper_bound_upper_half_q <= ramp_cfg_pkg::RST_BOUND_UPPER;
         upper_bound_lower_half_q <= ramp_cfg_pkg::RST_BOUND_LOWER;
      end else begin
         spare_word_a_q <= spare_word_a_d;
         calibration_start_and_threshold_top_q <= calibration_start_and_threshold_top_d;
         recal_threshold_upper_half_q <= recal_threshold_upper_half_d;
         recal_threshold_lower_half_q <= recal_threshold_lower_half_d;
         upper_bound_top_bit_q <= upper_bound_top_bit_d;
         upper_bound_upper_half_q <= upper_bound_upper_half_d;
         upper_bound_lower_half_q <= upper_bound_lower_half_d;
      end
   end

   // ----------------------------------------------------------------
   // Field extraction
   // ----------------------------------------------------------------
   assign ramp_recal_threshold = {
      calibration_start_and_threshold_top_q[ramp_cfg_pkg::THRESH_TOP_BIT],
      recal_threshold_upper_half_q, recal_threshold_lower_half_q};
   assign upper_bound_code = {upper_bound_top_bit_q[ramp_cfg_pkg::BOUND_TOP_BIT],
      upper_bound_upper_half_q,
      upper_bound_lower_half_q};
   // Fast recalibration only moves where the search begins, not how it runs
   assign fast_recal_select =
      calibration_start_and_threshold_top_q[ramp_cfg_pkg::FAST_RECAL_BIT];
   // Out-of-range codes above 183 are passed through; software must avoid them
   assign osc_cap_start_code = calibration_start_and_threshold_top_q[
      ramp_cfg_pkg::CAP_START_LSB +: ramp_cfg_pkg::CAP_W];

   // ----------------------------------------------------------------
   // Ramp bound clamping and offset tracking
   // ----------------------------------------------------------------
   ramp_bound_clamp u_clamp (
      .clk(clk),
      .rst_n(rst_n),
      .req_valid(ramp_req_valid),
      .req_code(ramp_req_code),
      .bound_code(upper_bound_code),
      .offset_q(ramp_offset),
      .clamped_q(clamped)
   );

   // ----------------------------------------------------------------
   // Recalibration flag
   // ----------------------------------------------------------------
   // The reference follows the offset only when a calibration finishes
   logic [32:0] cal_ref_q;
   logic [32:0] cal_ref_d;
   logic recal_needed_q;
   logic recal_needed_d;
   logic [32:0] moved;

   // Distance moved since the last finished calibration
   assign moved = code_gap(ramp_offset, cal_ref_q);

   always_comb begin
      cal_ref_d = cal_ref_q;
      recal_needed_d = recal_needed_q;
      if (cal_done) begin
         cal_ref_d = ramp_offset;
         recal_needed_d = 1'b0;
      end
      // A fresh excursion wins over a clear in the same cycle
      if (moved > ramp_recal_threshold) begin
         recal_needed_d = 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         cal_ref_q <= ramp_cfg_pkg::RST_CODE;
         recal_needed_q <= 1'b0;
      end else begin
         cal_ref_q <= cal_ref_d;
         recal_needed_q <= recal_needed_d;
      end
   end

   assign recal_needed = recal_needed_q;

   // ----------------------------------------------------------------
   // Calibration start point
   // ----------------------------------------------------------------
   cal_start_select u_start (
      .clk(clk),
      .rst_n(rst_n),
      .fast_recal_select(fast_recal_select),
      .osc_core_choice(osc_core_choice),
      .osc_cap_initial(osc_cap_start_code),
      .osc_bias_initial(osc_bias_initial),
      .cur_core(cur_core),
      .osc_cap_code(osc_cap_code),
      .cur_bias(cur_bias),
      .start_core_q(start_core),
      .start_cap_q(start_cap),
      .start_bias_q(start_bias)
   );

   // ----------------------------------------------------------------
   // Read path
   // ----------------------------------------------------------------
   // Status is live; the clamp bit reflects only the latest request
   always_comb begin
      status_word = 16'h0000;
      status_word[ramp_cfg_pkg::STAT_RECAL_BIT] = recal_needed_q;
      status_word[ramp_cfg_pkg::STAT_CLAMP_BIT] = clamped;
      status_word[ramp_cfg_pkg::STAT_FAST_BIT] = fast_recal_select;
   end

   // One 16-bit word per index; the upper half of the bus always reads zero
   always_comb begin
      unique case (idx)
         ramp_cfg_pkg::IDX_SPARE_WORD_A: rd_word = spare_word_a_q;
         ramp_cfg_pkg::IDX_CAL_START: rd_word = calibration_start_and_threshold_top_q;
         ramp_cfg_pkg::IDX_THRESH_UPPER: rd_word = recal_threshold_upper_half_q;
         ramp_cfg_pkg::IDX_THRESH_LOWER: rd_word = recal_threshold_lower_half_q;
         ramp_cfg_pkg::IDX_BOUND_TOP: rd_word = upper_bound_top_bit_q;
         ramp_cfg_pkg::IDX_BOUND_UPPER: rd_word = upper_bound_upper_half_q;
         ramp_cfg_pkg::IDX_BOUND_LOWER: rd_word = upper_bound_lower_half_q;
         ramp_cfg_pkg::IDX_RAMP_STATUS: rd_word = status_word;
         default: rd_word = 16'h0000;
      endcase
   end

   // Data is fetched in the setup cycle so it sits in a flop for the access
   always_comb begin
      prdata_d = prdata_q;
      if (rd_setup) begin
         prdata_d = {16'h0000, rd_word};
         // Misaligned or out-of-window reads return zero
         if (!map_hit(paddr)) begin
            prdata_d = 32'h00000000;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         prdata_q <= 32'h00000000;
      end else begin
         prdata_q <= prdata_d;
      end
   end
endmodule

/* ramp_cfg_pkg.sv */
package ramp_cfg_pkg;
   // ----------------------------------------------------------------
   // Register indices (byte address is four times the index)
   // ----------------------------------------------------------------
   localparam logic [7:0] IDX_SPARE_WORD_A = 8'h4D;
   localparam logic [7:0] IDX_CAL_START = 8'h4E;
   localparam logic [7:0] IDX_THRESH_UPPER = 8'h4F;
   localparam logic [7:0] IDX_THRESH_LOWER = 8'h50;
   localparam logic [7:0] IDX_BOUND_TOP = 8'h51;
   localparam logic [7:0] IDX_BOUND_UPPER = 8'h52;
   localparam logic [7:0] IDX_BOUND_LOWER = 8'h53;
   localparam logic [7:0] IDX_RAMP_STATUS = 8'h60;

   // ----------------------------------------------------------------
   // Bus and field layout
   // ----------------------------------------------------------------
   localparam int ADDR_W = 12;
   localparam int DATA_W = 32;
   localparam int REG_W = 16;
   localparam int CODE_W = 33;
   localparam int CAP_W = 8;
   localparam int CORE_W = 3;
   localparam int BIAS_W = 9;
   localparam int THRESH_TOP_BIT = 11;
   localparam int FAST_RECAL_BIT = 9;
   localparam int CAP_START_LSB = 1;
   localparam int BOUND_TOP_BIT = 0;
   localparam int STAT_RECAL_BIT = 0;
   localparam int STAT_CLAMP_BIT = 1;
   localparam int STAT_FAST_BIT = 2;

   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic [15:0] RST_SPARE_WORD_A = 16'h0000;
   localparam logic [15:0] RST_CAL_START = 16'h0064;
   localparam logic [15:0] RST_THRESH_UPPER = 16'h0000;
   localparam logic [15:0] RST_THRESH_LOWER = 16'h0000;
   localparam logic [15:0] RST_BOUND_TOP = 16'h0000;
   localparam logic [15:0] RST_BOUND_UPPER = 16'h0000;
   localparam logic [15:0] RST_BOUND_LOWER = 16'h0000;
   localparam logic [32:0] RST_CODE = 33'h000000000;
endpackage

/* ramp_bound_clamp.sv */
`timescale 1ns/1ps
// --------------------------------------------------------------------
// Clamps the requested ramp offset to the upper bound code
// --------------------------------------------------------------------
module ramp_bound_clamp (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic req_valid,
   input wire logic [32:0] req_code,
   input wire logic [32:0] bound_code,
   output logic [32:0] offset_q,
   output logic clamped_q
);
   logic [32:0] offset_d;
   logic clamped_d;

   always_comb begin
      offset_d = offset_q;
      clamped_d = clamped_q;
      if (req_valid) begin
         // Never let a request take the oscillator above the upper bound
         if (req_code > bound_code) begin
            offset_d = bound_code;
            clamped_d = 1'b1;
         end else begin
            offset_d = req_code;
            clamped_d = 1'b0;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         offset_q <= ramp_cfg_pkg::RST_CODE;
         clamped_q <= 1'b0;
      end else begin
         offset_q <= offset_d;
         clamped_q <= clamped_d;
      end
   end
endmodule

/* cal_start_select.sv */
`timescale 1ns/1ps
// --------------------------------------------------------------------
// Picks where the oscillator calibration begins
// --------------------------------------------------------------------
module cal_start_select (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic fast_recal_select,
   input wire logic [2:0] osc_core_choice,
   input wire logic [7:0] osc_cap_initial,
   input wire logic [8:0] osc_bias_initial,
   input wire logic [2:0] cur_core,
   input wire logic [7:0] osc_cap_code,
   input wire logic [8:0] cur_bias,
   output logic [2:0] start_core_q,
   output logic [7:0] start_cap_q,
   output logic [8:0] start_bias_q
);
   logic [2:0] start_core_d;
   logic [7:0] start_cap_d;
   logic [8:0] start_bias_d;

   always_comb begin
      // Reusing the live values saves search steps on small hops
      if (fast_recal_select) begin
         start_core_d = cur_core;
         start_cap_d = osc_cap_code;
         start_bias_d = cur_bias;
      end else begin
         start_core_d = osc_core_choice;
         start_cap_d = osc_cap_initial;
         start_bias_d = osc_bias_initial;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         start_core_q <= 3'h0;
         start_cap_q <= 8'h00;
         start_bias_q <= 9'h000;
      end else begin
         start_core_q <= start_core_d;
         start_cap_q <= start_cap_d;
         start_bias_q <= start_bias_d;
      end
   end
endmodule

/* ramp_cfg_monitor.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Port-level checks of the ramp and recalibration register bank
// ----------------------------------------------------------------
module ramp_cfg_monitor (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic ramp_req_valid,
   input wire logic [32:0] ramp_req_code,
   input wire logic cal_done,
   input wire logic [7:0] osc_cap_code,
   input wire logic [32:0] ramp_offset,
   input wire logic [32:0] ramp_recal_threshold,
   input wire logic [32:0] upper_bound_code,
   input wire logic recal_needed,
   input wire logic fast_recal_select,
   input wire logic [7:0] osc_cap_start_code,
   input wire logic [7:0] start_cap
);
   localparam logic [11:0] A_CAL = {2'h0, ramp_cfg_pkg::IDX_CAL_START, 2'h0};
   localparam logic [11:0] A_THU = {2'h0, ramp_cfg_pkg::IDX_THRESH_UPPER, 2'h0};
   localparam logic [11:0] A_THL = {2'h0, ramp_cfg_pkg::IDX_THRESH_LOWER, 2'h0};
   localparam logic [11:0] A_BT = {2'h0, ramp_cfg_pkg::IDX_BOUND_TOP, 2'h0};
   localparam logic [11:0] A_BU = {2'h0, ramp_cfg_pkg::IDX_BOUND_UPPER, 2'h0};
   localparam logic [11:0] A_BL = {2'h0, ramp_cfg_pkg::IDX_BOUND_LOWER, 2'h0};
   logic wr_ok;
   // Only full low-half writes are judged; partial strobes keep old bytes
   assign wr_ok = psel && penable && pwrite && pready && pstrb[1:0] == 2'h3;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);
   a_cal_fields: assert property (wr_ok && paddr == A_CAL |=>
      ramp_recal_threshold[32] == $past(pwdata[11]) && fast_recal_select == $past(pwdata[9])
      && osc_cap_start_code == $past(pwdata[8:1])) else $error("start word fields wrong");
   a_thresh_upper: assert property (wr_ok && paddr == A_THU |=>
      ramp_recal_threshold[31:16] == $past(pwdata[15:0])) else $error("threshold high wrong");
   a_thresh_lower: assert property (wr_ok && paddr == A_THL |=>
      ramp_recal_threshold[15:0] == $past(pwdata[15:0])) else $error("threshold low wrong");
   a_bound_top: assert property (wr_ok && paddr == A_BT |=>
      upper_bound_code[32] == $past(pwdata[0])) else $error("bound top bit wrong");
   a_bound_upper: assert property (wr_ok && paddr == A_BU |=>
      upper_bound_code[31:16] == $past(pwdata[15:0])) else $error("bound high wrong");
   a_bound_lower: assert property (wr_ok && paddr == A_BL |=>
      upper_bound_code[15:0] == $past(pwdata[15:0])) else $error("bound low wrong");
   a_offset_clamp: assert property (ramp_req_valid |=> ramp_offset ==
      ($past(ramp_req_code) > $past(upper_bound_code) ? $past(upper_bound_code)
      : $past(ramp_req_code))) else $error("ramp offset not clamped");
   a_offset_hold: assert property (!ramp_req_valid |=> $stable(ramp_offset))
      else $error("ramp offset moved without request");
   a_recal_sticky: assert property (recal_needed && !cal_done |=> recal_needed)
      else $error("recal flag dropped early");
   a_start_cap: assert property (1'b1 |=> start_cap == ($past(fast_recal_select)
      ? $past(osc_cap_code) : $past(osc_cap_start_code))) else $error("start cap wrong");
   a_read_upper: assert property (psel && penable && !pwrite |->
      prdata[31:16] == 16'h0000 && (!pslverr || prdata == 32'h0)) else $error("read data bad");
   a_ready_high: assert property (psel && penable |-> pready)
      else $error("access phase without ready");
   a_error_idle: assert property (!psel |-> !pslverr)
      else $error("error flag while bus idle");
   c_clamp: cover property (ramp_req_valid && ramp_req_code > upper_bound_code);
   c_recal: cover property ($rose(recal_needed));
   c_error: cover property (psel && penable && pslverr);
endmodule

bind ramp_bound_recal_config_regs ramp_cfg_monitor mon_u (.clk, .rst_n, .psel, .penable,
   .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .ramp_req_valid,
   .ramp_req_code, .cal_done, .osc_cap_code, .ramp_offset, .ramp_recal_threshold,
   .upper_bound_code, .recal_needed, .fast_recal_select, .osc_cap_start_code, .start_cap);

/* testbench.sv */
`timescale 1ns/1ps
module testbench;
   typedef struct {logic [11:0] a; logic [15:0] rv; logic [15:0] wv;} row_t;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, ramp_req_valid = 1'b0, cal_done = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [3:0] pstrb = 4'hF;
   logic [32:0] ramp_req_code = 33'h0;
   logic [2:0] osc_core_choice = 3'h2, cur_core = 3'h5, start_core;
   logic [8:0] osc_bias_initial = 9'h0C3, cur_bias = 9'h1AB, start_bias;
   logic [7:0] osc_cap_code = 8'h11, osc_cap_start_code, start_cap;
   logic [31:0] prdata, rdat;
   logic pready, pslverr, rerr, recal_needed, fast_recal_select;
   logic [32:0] ramp_offset, ramp_recal_threshold, upper_bound_code;
   int err_count = 0, tests_run = 0, cyc = 0;
   row_t rows [7] = '{'{12'h134, 16'h0000, 16'h0000}, '{12'h138, 16'h0064, 16'h096F},
      '{12'h13C, 16'h0000, 16'hA5C3}, '{12'h140, 16'h0000, 16'h3C5A},
      '{12'h144, 16'h0000, 16'h0001}, '{12'h148, 16'h0000, 16'h8001},
      '{12'h14C, 16'h0000, 16'h0F0F}};
   logic [11:0] bad [2] = '{12'h200, 12'h135};
   logic [32:0] reqs [3] = '{33'h1FFFFFFFF, 33'h180010F0F, 33'h000001000};
   logic [32:0] offs [3] = '{33'h180010F0F, 33'h180010F0F, 33'h000001000};

   ramp_bound_recal_config_regs dut_u (.clk, .rst_n, .psel, .penable, .pwrite, .paddr,
      .pwdata, .pstrb, .prdata, .pready, .pslverr, .ramp_req_valid, .ramp_req_code,
      .cal_done, .osc_core_choice, .osc_bias_initial, .cur_core, .osc_cap_code, .cur_bias,
      .ramp_offset, .ramp_recal_threshold, .upper_bound_code, .recal_needed,
      .fast_recal_select, .osc_cap_start_code, .start_core, .start_cap, .start_bias);

   always #2.5 clk = ~clk;

   // ----------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------
   task automatic test_done;
      $display("checks %0d mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   task automatic chk(input string n, input logic [32:0] e, input logic [32:0] g);
      tests_run++;
      if (g !== e) begin
         err_count++;
         $display("MISMATCH %s expected %h seen %h", n, e, g);
      end
   endtask

   // Starts on an edge so back-to-back calls never assign psel twice in one step
   task automatic apb(input logic w, input logic [11:0] a, input logic [15:0] d);
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= {16'h0000, d};
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic ramp(input logic [32:0] c);
      @(posedge clk);
      ramp_req_valid <= 1'b1;
      ramp_req_code <= c;
      @(posedge clk);
      ramp_req_valid <= 1'b0;
      @(posedge clk);
   endtask

   // Two edges: the first may still see the old reference and keep the flag set
   task automatic cal;
      @(posedge clk);
      cal_done <= 1'b1;
      repeat (2) @(posedge clk);
      cal_done <= 1'b0;
      @(posedge clk);
   endtask

   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         err_count++;
         test_done();
      end
   end

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      foreach (rows[i]) begin
         apb(1'b0, rows[i].a, 16'h0000);
         chk("reset value", {17'h0, rows[i].rv}, {1'b0, rdat});
      end
      foreach (rows[i]) begin
         apb(1'b1, rows[i].a, rows[i].wv);
         apb(1'b0, rows[i].a, 16'h0000);
         chk("read back", {17'h0, rows[i].wv}, {1'b0, rdat});
         chk("mapped error", 33'h0, {32'h0, rerr});
      end
      chk("threshold", 33'h1A5C33C5A, ramp_recal_threshold);
      chk("bound", 33'h180010F0F, upper_bound_code);
      chk("cap start", 33'h0B7, {25'h0, osc_cap_start_code});
      pstrb <= 4'h1;
      apb(1'b1, 12'h13C, 16'hFFFF);
      pstrb <= 4'hF;
      apb(1'b0, 12'h13C, 16'h0000);
      chk("byte strobe", 33'h0A5FF, {1'b0, rdat});
      $display("register table done");
      foreach (bad[i]) begin
         apb(1'b1, bad[i], 16'hFFFF);
         chk("write error", 33'h1, {32'h0, rerr});
         apb(1'b0, bad[i], 16'h0000);
         chk("error flag", 33'h1, {32'h0, rerr});
         chk("error data", 33'h0, {1'b0, rdat});
      end
      chk("bound kept", 33'h180010F0F, upper_bound_code);
      $display("bad address done");
      foreach (reqs[i]) begin
         ramp(reqs[i]);
         chk("ramp offset", offs[i], ramp_offset);
         apb(1'b0, 12'h180, 16'h0000);
         chk("clamp status", (i == 0) ? 33'h2 : 33'h0, {1'b0, rdat});
      end
      $display("clamp done");
      apb(1'b1, 12'h138, 16'h016F);
      apb(1'b1, 12'h13C, 16'h0000);
      apb(1'b1, 12'h140, 16'h0100);
      cal();
      chk("recal cleared", 33'h0, {32'h0, recal_needed});
      for (int i = 0; i < 2; i++) begin
         ramp(33'h000001100 + 33'(i));
         @(posedge clk);
         chk("recal flag", 33'(i), {32'h0, recal_needed});
      end
      apb(1'b0, 12'h180, 16'h0000);
      chk("status recal", 33'h1, {1'b0, rdat});
      cal();
      chk("recal after cal", 33'h0, {32'h0, recal_needed});
      $display("recal done");
      for (int f = 0; f < 2; f++) begin
         apb(1'b1, 12'h138, (f == 1) ? 16'h036F : 16'h016F);
         repeat (2) @(posedge clk);
         chk("start values", (f == 1) ? {13'h0, 3'h5, 8'h11, 9'h1AB}
            : {13'h0, 3'h2, 8'hB7, 9'h0C3}, {13'h0, start_core, start_cap, start_bias});
      end
      $display("start select done");
      @(posedge clk);
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      apb(1'b0, 12'h138, 16'h0000);
      chk("second reset", 33'h064, {1'b0, rdat});
      chk("offset reset", 33'h0, ramp_offset);
      $display("second reset done");
      test_done();
   end
endmodule
